// ===== verilog/hca_alarm_logic.sv
// Purpose: heater open and short alarm supervision on two current sense channels
// Assumes: samples arrive with sampleValid, synchronous to clock, 0.1 A per count
// Notes:   registers over a zero-wait APB slave; one level interrupt output
//
// Summary of operation
// - short alarm from off-time leakage over threshold
// - skip short check on short off intervals
// - short check uses heating output only
// - aux output one shows short alarm after reset
// - integrated alarm ORs general and heater alarms
// - short enable gates short alarm, default on
// - thresholds 0.1 to 49.9 A detect normally
// - threshold 0.0: open off, short on
// - threshold 50.0: open on, short off
// - monitors saturate to FFFF above 55.0 A
// - alarms never stop temperature control
// - two channels with own thresholds, sharing hysteresis and control settings
// - open alarm from on-time current below threshold
// - skip open check on short on intervals
// - latch holds alarm until cleared
`timescale 1ns/10ps

module hca_alarm_logic
  import hca_pkg::*;
#(
  parameter int unsigned LONG_SKIP_CYCLES      = hca_pkg::SKIP_LONG_CYC,
  parameter int unsigned SHORT_OFF_SKIP_CYCLES = hca_pkg::SKIP_SHORT_OFF_CYC,
  parameter int unsigned SHORT_ON_SKIP_CYCLES  = hca_pkg::SKIP_SHORT_ON_CYC
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // control outputs and samples
  input  wire logic                       heatOutput,
  input  wire logic                       coolOutput,
  input  wire logic                       sampleValid,
  input  wire logic [hca_pkg::CUR_W-1:0]  senseInputOne,
  input  wire logic [hca_pkg::CUR_W-1:0]  senseInputTwo,
  input  wire logic [3:0]                 generalAlarm,
  input  wire logic                       latchClearEvent,
  // alarm outputs
  output logic [3:0]                      auxOutput,
  output logic                            integratedAlarm,
  output logic                            irq
);
  import hca_pkg::*;

  // configuration
  logic [5:0]       ctrl;
  logic [THR_W-1:0] shortHyst;
  logic [THR_W-1:0] openHyst;
  logic [THR_W-1:0] shortThr [2];
  logic [THR_W-1:0] openThr  [2];
  logic [7:0]       auxSel;
  logic [3:0]       intStatus;
  logic [3:0]       intMask;

  // status
  logic [CUR_W-1:0] heatMon [2];
  logic [CUR_W-1:0] leakMon [2];
  logic [1:0]       shortAlarm;
  logic [1:0]       openAlarm;
  logic [1:0]       shortAlarmPrev;
  logic [1:0]       openAlarmPrev;

  // bus decode
  logic        setupPhase;
  logic        writeTaken;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        latchClear;

  assign setupPhase = psel & ~penable;
  assign writeTaken = psel & penable & pready & pwrite;
  assign latchClear = latchClearEvent | (writeTaken && paddr == OFS_CTRL && pwdata[CTRL_LATCH_CLR]);

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      OFS_CTRL:      next_prdata[4:0] = ctrl[4:0];
      OFS_HYST:      next_prdata = {6'h00, openHyst, 6'h00, shortHyst};
      OFS_SHORT_THR: next_prdata = {6'h00, shortThr[1], 6'h00, shortThr[0]};
      OFS_OPEN_THR:  next_prdata = {6'h00, openThr[1], 6'h00, openThr[0]};
      OFS_HEAT_MON:  next_prdata = {heatMon[1], heatMon[0]};
      OFS_LEAK_MON:  next_prdata = {leakMon[1], leakMon[0]};
      OFS_AUX_SEL:   next_prdata[7:0] = auxSel;
      OFS_ALARMS:    next_prdata[7:0] = {generalAlarm, openAlarm, shortAlarm};
      OFS_INT_STAT:  next_prdata[3:0] = intStatus;
      OFS_INT_MASK:  next_prdata[3:0] = intMask;
      default:       next_pslverr = 1'b1;
    endcase
  end

  // zero-wait slave: answer is ready in the access cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase & next_pslverr;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // configuration writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl        <= CTRL_RESET;
      shortHyst   <= HYST_RESET;
      openHyst    <= HYST_RESET;
      shortThr[0] <= SHORT_THR_RESET;
      shortThr[1] <= SHORT_THR_RESET;
      openThr[0]  <= OPEN_THR_RESET;
      openThr[1]  <= OPEN_THR_RESET;
      auxSel      <= AUX_SEL_RESET;
      intMask     <= 4'h0;
    end else if (writeTaken) begin
      unique case (paddr)
        OFS_CTRL: begin
          ctrl <= {1'b0, pwdata[4:0]};
        end
        OFS_HYST: begin
          shortHyst <= pwdata[THR_W-1:0];
          openHyst  <= pwdata[CH_STRIDE+THR_W-1:CH_STRIDE];
        end
        OFS_SHORT_THR: begin
          shortThr[0] <= pwdata[THR_W-1:0];
          shortThr[1] <= pwdata[CH_STRIDE+THR_W-1:CH_STRIDE];
        end
        OFS_OPEN_THR: begin
          openThr[0] <= pwdata[THR_W-1:0];
          openThr[1] <= pwdata[CH_STRIDE+THR_W-1:CH_STRIDE];
        end
        OFS_AUX_SEL: begin
          auxSel <= pwdata[7:0];
        end
        OFS_INT_MASK: begin
          intMask <= pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // interval timing of the heating output; cooling output never qualifies
  logic             heatPrev;
  logic [CNT_W-1:0] intervalCount;
  logic [CNT_W-1:0] offLimit;
  logic [CNT_W-1:0] onLimit;
  logic             offQualified;
  logic             onQualified;

  assign offLimit = ctrl[CTRL_FAST_PERIOD] ? CNT_W'(SHORT_OFF_SKIP_CYCLES) : CNT_W'(LONG_SKIP_CYCLES);
  assign onLimit  = ctrl[CTRL_FAST_PERIOD] ? CNT_W'(SHORT_ON_SKIP_CYCLES) : CNT_W'(LONG_SKIP_CYCLES);
  // interval still running, so it only qualifies once it outlasts the limit
  assign offQualified = ~heatOutput & ~heatPrev & (intervalCount > offLimit);
  assign onQualified  = heatOutput & heatPrev & (intervalCount > onLimit);

  always_ff @(posedge clock) begin
    if (rst) begin
      heatPrev      <= 1'b0;
      intervalCount <= '0;
    end else begin
      heatPrev <= heatOutput;
      if (heatOutput != heatPrev) begin
        intervalCount <= '0;
      end else if (intervalCount != {CNT_W{1'b1}}) begin
        intervalCount <= intervalCount + 1'b1;
      end
    end
  end

  // per-channel detection
  logic [CUR_W-1:0] sample [2];
  assign sample[0] = senseInputOne;
  assign sample[1] = senseInputTwo;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic             rawShort;
      logic             rawOpen;
      logic             next_rawShort;
      logic             next_rawOpen;
      logic [CUR_W:0]   curWide;
      logic [CUR_W:0]   shortThrWide;
      logic [CUR_W:0]   openThrWide;
      logic [CUR_W-1:0] monValue;

      assign curWide      = {1'b0, sample[ch]};
      assign shortThrWide = (CUR_W+1)'(shortThr[ch]);
      assign openThrWide  = (CUR_W+1)'(openThr[ch]);
      assign monValue     = (sample[ch] > MON_MAX) ? MON_OVER : sample[ch];

      always_comb begin
        next_rawShort = rawShort;
        if (shortThr[ch] == THR_OFF_LOW) begin
          next_rawShort = 1'b1;
        end else if (shortThr[ch] == THR_OFF_HIGH) begin
          next_rawShort = 1'b0;
        end else if (sampleValid && offQualified) begin
          if (curWide > shortThrWide) begin
            next_rawShort = 1'b1;
          end else if (curWide + (CUR_W+1)'(shortHyst) <= shortThrWide) begin
            next_rawShort = 1'b0;
          end
        end
      end

      always_comb begin
        next_rawOpen = rawOpen;
        if (openThr[ch] == THR_OFF_LOW) begin
          next_rawOpen = 1'b0;
        end else if (openThr[ch] == THR_OFF_HIGH) begin
          next_rawOpen = 1'b1;
        end else if (sampleValid && onQualified) begin
          if (curWide < openThrWide) begin
            next_rawOpen = 1'b1;
          end else if (curWide >= openThrWide + (CUR_W+1)'(openHyst)) begin
            next_rawOpen = 1'b0;
          end
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          rawShort <= 1'b0;
          rawOpen  <= 1'b0;
        end else begin
          rawShort <= next_rawShort;
          rawOpen  <= next_rawOpen;
        end
      end

      // latch keeps an alarm up until cleared; enable off forces it down
      always_ff @(posedge clock) begin
        if (rst) begin
          shortAlarm[ch] <= 1'b0;
          openAlarm[ch]  <= 1'b0;
        end else begin
          shortAlarm[ch] <= ctrl[CTRL_SHORT_EN] &
                            (next_rawShort | (ctrl[CTRL_SHORT_LATCH] & shortAlarm[ch] & ~latchClear));
          openAlarm[ch]  <= ctrl[CTRL_OPEN_EN] &
                            (next_rawOpen | (ctrl[CTRL_OPEN_LATCH] & openAlarm[ch] & ~latchClear));
        end
      end

      // monitors: on-time samples show heater current, off-time ones leakage
      always_ff @(posedge clock) begin
        if (rst) begin
          heatMon[ch] <= '0;
          leakMon[ch] <= '0;
        end else if (sampleValid) begin
          if (heatOutput) begin
            heatMon[ch] <= monValue;
          end else begin
            leakMon[ch] <= monValue;
          end
        end
      end
    end
  endgenerate

  // interrupt events on alarm assertion; set wins over write-one-clear
  logic [3:0] alarmRise;
  assign alarmRise = {openAlarm & ~openAlarmPrev, shortAlarm & ~shortAlarmPrev};

  always_ff @(posedge clock) begin
    if (rst) begin
      shortAlarmPrev <= 2'b00;
      openAlarmPrev  <= 2'b00;
      intStatus      <= 4'h0;
      irq            <= 1'b0;
    end else begin
      shortAlarmPrev <= shortAlarm;
      openAlarmPrev  <= openAlarm;
      if (writeTaken && paddr == OFS_INT_STAT) begin
        intStatus <= (intStatus & ~pwdata[3:0]) | alarmRise;
      end else begin
        intStatus <= intStatus | alarmRise;
      end
      irq <= |(intStatus & intMask);
    end
  end

  // alarm routing; purely indicative, never fed back to the heat output
  logic combinedAlarm;
  assign combinedAlarm = |shortAlarm | |openAlarm;

  always_ff @(posedge clock) begin
    if (rst) begin
      auxOutput       <= 4'h0;
      integratedAlarm <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        unique case (hca_sel_t'(auxSel[2*i +: 2]))
          HCA_SEL_NONE:     auxOutput[i] <= 1'b0;
          HCA_SEL_SHORT:    auxOutput[i] <= |shortAlarm;
          HCA_SEL_OPEN:     auxOutput[i] <= |openAlarm;
          HCA_SEL_COMBINED: auxOutput[i] <= combinedAlarm;
        endcase
      end
      integratedAlarm <= |generalAlarm | combinedAlarm;
    end
  end

  // cooling output takes no part in detection
  logic unusedCool;
  assign unusedCool = coolOutput;

endmodule : hca_alarm_logic

// ===== pkg/hca_pkg.sv
// Purpose: shared constants for the heater current alarm logic
// Assumes: currents are unsigned counts of 0.1 A; 10 MHz system clock
// Notes:   register offsets are byte addresses on a 32-bit APB
package hca_pkg;

  // clock and timing
  localparam int unsigned CLOCK_HZ        = 10_000_000;
  localparam int unsigned SKIP_LONG_MS    = 100;
  localparam int unsigned SKIP_SHORT_OFF_MS = 35;
  localparam int unsigned SKIP_SHORT_ON_MS  = 30;
  localparam int unsigned SKIP_LONG_CYC      = SKIP_LONG_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SKIP_SHORT_OFF_CYC = SKIP_SHORT_OFF_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SKIP_SHORT_ON_CYC  = SKIP_SHORT_ON_MS * (CLOCK_HZ / 1000);
  localparam int unsigned CNT_W = 24;

  // current scale, 0.1 A per count
  localparam int unsigned CUR_W = 16;
  localparam int unsigned THR_W = 10;
  localparam logic [THR_W-1:0] THR_OFF_LOW  = 10'h000;  // 0.0 A
  localparam logic [THR_W-1:0] THR_OFF_HIGH = 10'h1F4;  // 50.0 A
  localparam logic [CUR_W-1:0] MON_MAX      = 16'h0226; // 55.0 A
  localparam logic [CUR_W-1:0] MON_OVER     = 16'hFFFF;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_HYST      = 8'h04;
  localparam logic [7:0] OFS_SHORT_THR = 8'h08;
  localparam logic [7:0] OFS_OPEN_THR  = 8'h0C;
  localparam logic [7:0] OFS_HEAT_MON  = 8'h10;
  localparam logic [7:0] OFS_LEAK_MON  = 8'h14;
  localparam logic [7:0] OFS_AUX_SEL   = 8'h18;
  localparam logic [7:0] OFS_ALARMS    = 8'h1C;
  localparam logic [7:0] OFS_INT_STAT  = 8'h20;
  localparam logic [7:0] OFS_INT_MASK  = 8'h24;

  // control register fields
  localparam int unsigned CTRL_SHORT_EN    = 0;
  localparam int unsigned CTRL_OPEN_EN     = 1;
  localparam int unsigned CTRL_SHORT_LATCH = 2;
  localparam int unsigned CTRL_OPEN_LATCH  = 3;
  localparam int unsigned CTRL_FAST_PERIOD = 4;
  localparam int unsigned CTRL_LATCH_CLR   = 5;
  localparam logic [5:0]  CTRL_RESET       = 6'h03;

  // per-channel fields: channel one in [9:0], channel two in [25:16]
  localparam int unsigned CH_STRIDE = 16;
  localparam logic [THR_W-1:0] HYST_RESET      = 10'h001; // 0.1 A
  localparam logic [THR_W-1:0] SHORT_THR_RESET = 10'h1F4; // 50.0 A
  localparam logic [THR_W-1:0] OPEN_THR_RESET  = 10'h000; // 0.0 A

  // aux output selector codes, two bits per output
  typedef enum logic [1:0] {
    HCA_SEL_NONE,
    HCA_SEL_SHORT,
    HCA_SEL_OPEN,
    HCA_SEL_COMBINED
  } hca_sel_t;
  localparam logic [7:0] AUX_SEL_RESET = 8'h01;

endpackage : hca_pkg

// ===== dv/hca_alarm_assertions.sv
// Purpose: port-level checks of the heater current alarm block
// Assumes: zero-wait APB slave, registered alarm outputs
// Notes:   attached to every instance of the block by bind
`timescale 1ns/10ps

module hca_alarm_assertions
  import hca_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // alarms
  input wire logic [3:0]  generalAlarm,
  input wire logic [3:0]  auxOutput,
  input wire logic        integratedAlarm
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_needs_setup: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_error_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_read_data_holds: assert property (!$past(psel && !penable) && !$past(rst) |-> $stable(prdata))
    else $error("read data moved between setups");
  a_monitor_in_range: assert property (
    pready && $past(psel && !pwrite && (paddr == OFS_HEAT_MON || paddr == OFS_LEAK_MON))
    |-> (prdata[15:0] <= MON_MAX || prdata[15:0] == MON_OVER)
     && (prdata[31:16] <= MON_MAX || prdata[31:16] == MON_OVER))
    else $error("monitor outside range");
  a_general_sets_alarm: assert property (generalAlarm != 4'h0 |=> integratedAlarm)
    else $error("general alarm not in integrated alarm");
  a_aux_in_integrated: assert property (auxOutput != 4'h0 |-> integratedAlarm)
    else $error("heater alarm missing from integrated alarm");
endmodule : hca_alarm_assertions

bind hca_alarm_logic hca_alarm_assertions hca_alarm_assertions_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .generalAlarm(generalAlarm),
  .auxOutput(auxOutput), .integratedAlarm(integratedAlarm));

// ===== dv/hca_sense_model.sv
// Purpose: two current sense channels feeding samples to the block
// Assumes: one sample every four clocks
// Notes:   lines toggle between samples so stale values are never trusted
`timescale 1ns/10ps

module hca_sense_model
  import hca_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // load state, channel two in the upper half
  input  wire logic                 heatOutput,
  input  wire logic [31:0]          onAmps,
  input  wire logic [31:0]          offAmps,
  // samples
  output logic                      sampleValid,
  output logic [hca_pkg::CUR_W-1:0] senseInputOne,
  output logic [hca_pkg::CUR_W-1:0] senseInputTwo
);
  logic [1:0] phase;

  always_ff @(posedge clock) begin
    phase       <= rst ? 2'h0 : phase + 2'h1;
    sampleValid <= !rst && phase == 2'h3;
    if (phase == 2'h3) begin
      {senseInputTwo, senseInputOne} <= heatOutput ? onAmps : offAmps;
    end else begin
      {senseInputTwo, senseInputOne} <= ~{senseInputTwo, senseInputOne};
    end
  end
endmodule : hca_sense_model

// ===== dv/hca_alarm_logic_tb.sv
// Purpose: self-checking bench for the heater current alarm block
// Assumes: skip counts shortened to 20/7/6 cycles
// Notes:   register reads are checked by a monitor from a queue
`timescale 1ns/10ps
`define CHECK(what, exp, act) begin n_compared++; if ((act) !== (exp)) begin failures++; \
  $display("wrong value %s expected %h seen %h", what, exp, act); end end

module hca_alarm_logic_tb;
  import hca_pkg::*;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, heatOutput, coolOutput;
  logic        sampleValid, latchClearEvent, integratedAlarm, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, onAmps, offAmps;
  logic [15:0] senseInputOne, senseInputTwo, leak;
  logic [3:0]  generalAlarm, auxOutput, gen;
  logic [32:0] expQ[$];
  logic [32:0] want;
  int          failures, n_compared, seed;

  hca_alarm_logic #(.LONG_SKIP_CYCLES(20), .SHORT_OFF_SKIP_CYCLES(7), .SHORT_ON_SKIP_CYCLES(6)) hca_alarm_logic_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .heatOutput(heatOutput),
    .coolOutput(coolOutput), .sampleValid(sampleValid), .senseInputOne(senseInputOne),
    .senseInputTwo(senseInputTwo), .generalAlarm(generalAlarm), .latchClearEvent(latchClearEvent),
    .auxOutput(auxOutput), .integratedAlarm(integratedAlarm), .irq(irq));
  hca_sense_model hca_sense_model_i (.clock(clock), .rst(rst), .heatOutput(heatOutput), .onAmps(onAmps),
    .offAmps(offAmps), .sampleValid(sampleValid), .senseInputOne(senseInputOne), .senseInputTwo(senseInputTwo));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic summarize;
    `CHECK("queue left", 0, expQ.size())
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // an idle cycle after each transfer keeps every strobe to one assignment per step
  // no wait-state count is assumed; a slave that never answers is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back({1'b0, exp});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic hold(input logic heat, input int n);
    heatOutput <= heat;
    coolOutput <= ~heat;
    repeat (n) @(posedge clock);
  endtask : hold

  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite) begin
      want = expQ.size() > 0 ? expQ.pop_front() : 33'h1_DEAD_BEEF;
      `CHECK("read data", want, {pslverr, prdata})
    end
  end

  initial begin
    #(20000 * 100);
    failures++;
    summarize();
  end

  initial begin
    seed = 54957;
    {psel, penable, pwrite, paddr, pwdata, heatOutput, coolOutput, latchClearEvent} = '0;
    {generalAlarm, onAmps, offAmps} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFS_CTRL, 32'h0000_0003);
    rd(OFS_HYST, 32'h0001_0001);
    rd(OFS_SHORT_THR, 32'h01F4_01F4);
    rd(OFS_OPEN_THR, 32'h0000_0000);
    rd(OFS_AUX_SEL, 32'h0000_0001);
    rd(OFS_INT_MASK, 32'h0000_0000);
    expQ.push_back({1'b1, 32'h0000_0000});
    apb(1'b0, 8'h40, 32'h0000_0000);
    apb(1'b1, OFS_SHORT_THR, 32'h01F4_0064);
    apb(1'b1, OFS_INT_MASK, 32'h0000_000F);
    leak = 16'(101 + ($unsigned($random(seed)) % 449));
    offAmps <= {16'h0000, leak};
    hold(1'b0, 40);
    rd(OFS_ALARMS, 32'h0000_0001);
    rd(OFS_LEAK_MON, {16'h0000, leak});
    `CHECK("aux output", 4'h1, auxOutput)
    `CHECK("integrated alarm", 1'b1, integratedAlarm)
    `CHECK("irq", 1'b1, irq)
    offAmps <= 32'h0000_0226;
    hold(1'b0, 12);
    rd(OFS_LEAK_MON, 32'h0000_0226);
    offAmps <= 32'h0000_0227;
    hold(1'b0, 12);
    rd(OFS_LEAK_MON, 32'h0000_FFFF);
    offAmps <= 32'h0000_0064;
    hold(1'b0, 12);
    rd(OFS_ALARMS, 32'h0000_0001);
    offAmps <= 32'h0000_0063;
    hold(1'b0, 12);
    rd(OFS_ALARMS, 32'h0000_0000);
    apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
    rd(OFS_INT_STAT, 32'h0000_0000);
    `CHECK("irq", 1'b0, irq)
    // off intervals under the long limit never qualify, on-time current never counts as leakage
    offAmps <= 32'h0000_012C;
    onAmps  <= 32'h012C_012C;
    repeat (4) begin
      hold(1'b1, 30);
      hold(1'b0, 15);
    end
    hold(1'b1, 30);
    rd(OFS_ALARMS, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0013);
    hold(1'b1, 10);
    // long enough past the fast limit that at least one sample lands in the qualified window
    hold(1'b0, 16);
    rd(OFS_ALARMS, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0012);
    hold(1'b0, 12);
    rd(OFS_ALARMS, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    apb(1'b1, OFS_SHORT_THR, 32'h01F4_01F4);
    apb(1'b1, OFS_OPEN_THR, 32'h00C8_0000);
    apb(1'b1, OFS_AUX_SEL, 32'h0000_000D);
    apb(1'b1, OFS_INT_STAT, 32'h0000_000F);
    apb(1'b1, OFS_INT_MASK, 32'h0000_0007);
    onAmps <= 32'h0032_012C;
    hold(1'b0, 30);
    hold(1'b1, 15);
    hold(1'b0, 4);
    rd(OFS_ALARMS, 32'h0000_0000);
    hold(1'b1, 40);
    rd(OFS_ALARMS, 32'h0000_0008);
    rd(OFS_HEAT_MON, 32'h0032_012C);
    `CHECK("aux output", 4'h2, auxOutput)
    rd(OFS_INT_STAT, 32'h0000_0008);
    `CHECK("masked irq", 1'b0, irq)
    apb(1'b1, OFS_CTRL, 32'h0000_000B);
    onAmps <= 32'h012C_012C;
    hold(1'b1, 30);
    rd(OFS_ALARMS, 32'h0000_0008);
    latchClearEvent <= 1'b1;
    @(posedge clock);
    latchClearEvent <= 1'b0;
    hold(1'b1, 8);
    rd(OFS_ALARMS, 32'h0000_0000);
    apb(1'b1, OFS_SHORT_THR, 32'h01F4_0000);
    apb(1'b1, OFS_OPEN_THR, 32'h01F4_0000);
    hold(1'b1, 8);
    rd(OFS_ALARMS, 32'h0000_0009);
    gen = 4'($random(seed)) | 4'h1;
    generalAlarm <= gen;
    hold(1'b1, 4);
    `CHECK("integrated alarm", 1'b1, integratedAlarm)
    rd(OFS_ALARMS, {24'h00_0000, gen, 4'h9});
    // every selector code once: none, short, open, combined
    apb(1'b1, OFS_AUX_SEL, 32'h0000_00E4);
    hold(1'b1, 2);
    `CHECK("aux output", 4'hE, auxOutput)
    // short latch holds past a cleared cause until a latch-clear write
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    apb(1'b1, OFS_SHORT_THR, 32'h01F4_01F4);
    hold(1'b1, 4);
    rd(OFS_ALARMS, {24'h00_0000, gen, 4'h9});
    apb(1'b1, OFS_CTRL, 32'h0000_0027);
    rd(OFS_ALARMS, {24'h00_0000, gen, 4'h8});
    // mid-run reset brings back the power-up settings
    generalAlarm <= 4'h0;
    rst          <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFS_CTRL, 32'h0000_0003);
    rd(OFS_ALARMS, 32'h0000_0000);
    rd(OFS_SHORT_THR, 32'h01F4_01F4);
    summarize();
  end
endmodule : hca_alarm_logic_tb
